// ==== contact_bank.sv ====
// external contacts wired to the input terminals
// assumes the bench commands contact states; contacts move just after a rising edge
`timescale 1ns/1ps
module contact_bank (
    // clock
    input wire clk,
    // contact commands and terminal levels
    input wire [8:0] close,
    output reg [8:0] pins
);
    // open contacts are pulled low, so an open terminal reads 0
    initial pins = 9'h000;
    always @(posedge clk) begin
        pins <= #1 close;
    end
endmodule

// ==== input_debounce.v ====
// one terminal: three-stage synchroniser then stability filter in ms ticks
// assumes a shared 1 ms tick pulse and a filter time already clamped to its range
`timescale 1ns/1ps
`include "mfi_decoder_map.vh"

module input_debounce (
    // clock and reset
    input wire clk,
    input wire resetn,
    // timing
    input wire ms_tick,
    input wire [`FILTER_MS_W-1:0] filter_ms,
    // terminal
    input wire pin,
    output reg level
);

reg sync1;
reg sync2;
reg sync3;
reg [`FILTER_MS_W-1:0] count;

always @(posedge clk) begin
    if (!resetn) begin
        sync1 <= 1'b0;
        sync2 <= 1'b0;
        sync3 <= 1'b0;
        count <= {`FILTER_MS_W{1'b0}};
        level <= 1'b0;
    end else begin
        sync1 <= pin;
        sync2 <= sync1;
        sync3 <= sync2;
        // a candidate counts only where stages two and three agree
        if (sync2 != sync3 || sync3 == level) begin
            count <= {`FILTER_MS_W{1'b0}};
        end else if (ms_tick) begin
            if (count + 6'h01 >= filter_ms) begin
                level <= sync3;
                count <= {`FILTER_MS_W{1'b0}};
            end else begin
                count <= count + 6'h01;
            end
        end
    end
end

endmodule

// ==== mfi_decoder.v ====
// multifunction digital input decoder for function codes 17 to 36
// assumes raw terminal pins from outside the clock domain and static configuration ports
//
// Summary of operation
// - function 17 zeroes the increment/decrement setpoint
// - zero-clear touches only that setpoint source
// - external fault latches fault code, forces stop
// - function 19 is third wire, three-line only
// - stopping below brake threshold, brake while 20 held
// - brake ends on release; duration ignored
// - function 21 holds frequency, suspends ramping
// - function 22 switches process loop, terminal mode
// - function 23 gates staged program, mode 2
// - function 24 runs swing pattern, mode 2
// - 24 released: ramp to swing preset
// - function 25 gates compensation loop, mode 2
// - function 26 clears retained staged position
// - function 27 clears retained swing state
// - functions 28-30 form setpoint stage code
// - function 31 selects loop setpoint source
// - function 32 selects loop feedback source
// - function 33 activates loop sleep, mode 2
// - function 34 chooses speed or torque mode
// - function 35 chooses minimum torque limit
// - function 36 switches upper torque limit
// - asserted 36 selects maximum limit 2
// - changes accepted only after filter time
`timescale 1ns/1ps
`include "mfi_decoder_map.vh"

module mfi_decoder (
    // clock and reset
    input wire clk,
    input wire resetn,
    // terminals and their function codes, terminal n in bits n*7 up
    input wire [`NUM_TERMINALS-1:0] terminal_pin,
    input wire [`NUM_TERMINALS*`FUNC_CODE_W-1:0] terminal_func,
    // filter times, low group terminals 0-4, high group 5-8
    input wire [`FILTER_MS_W-1:0] input_filter_time_low_group,
    input wire [`FILTER_MS_W-1:0] input_filter_time_high_group,
    // configuration digits
    input wire [3:0] run_command_source,
    input wire [3:0] terminal_wiring_mode,
    input wire [3:0] staged_program_mode_run,
    input wire [3:0] staged_program_mode_memory,
    input wire [3:0] swing_run_config_enable,
    input wire [3:0] swing_run_config_memory,
    input wire [3:0] compensation_loop_enable_source,
    input wire [3:0] loop_sleep_source,
    input wire proc_loop_terminal_select,
    // drive state
    input wire decel_stopping,
    input wire below_brake_threshold,
    input wire fault_clear,
    // actions
    output reg updn_setpoint_clear,
    output reg ext_fault_stop,
    output reg [7:0] fault_code,
    output reg three_line_enable,
    output reg three_line_stop_n,
    output reg dc_brake_hold,
    output reg dc_brake_timer_ignore,
    output reg ramp_hold,
    output reg proc_loop_enable,
    output reg staged_program_enable,
    output reg swing_enable,
    output reg swing_to_preset,
    output reg comp_loop_enable,
    output reg staged_position_clear,
    output reg swing_state_clear,
    output reg [2:0] setpoint_stage,
    output reg setpoint_source_2,
    output reg feedback_source_2,
    output reg loop_sleep,
    output reg speed_mode,
    output reg min_torque_limit_2,
    output reg max_torque_limit_2
);

localparam [`FILTER_MS_W-1:0] FILTER_MIN = `FILTER_MIN_MS;
localparam [`FILTER_MS_W-1:0] FILTER_MAX = `FILTER_MAX_MS;
localparam [`MS_TICK_W-1:0] TICK_LAST = `MS_TICK_LAST;
localparam [`MS_TICK_W-1:0] TICK_ONE = `MS_TICK_W'h00001;

// out of range settings fall back to the nearest limit rather than stalling the filter
function [`FILTER_MS_W-1:0] clamp_ms;
    input [`FILTER_MS_W-1:0] value;
    begin
        if (value < FILTER_MIN) begin
            clamp_ms = FILTER_MIN;
        end else if (value > FILTER_MAX) begin
            clamp_ms = FILTER_MAX;
        end else begin
            clamp_ms = value;
        end
    end
endfunction

// or of the filtered levels whose terminal carries the given code
function func_active;
    input [`NUM_TERMINALS-1:0] levels;
    input [`NUM_TERMINALS*`FUNC_CODE_W-1:0] codes;
    input [`FUNC_CODE_W-1:0] code;
    integer i;
    begin
        func_active = 1'b0;
        for (i = 0; i < `NUM_TERMINALS; i = i + 1) begin
            if (codes[i*`FUNC_CODE_W +: `FUNC_CODE_W] == code && levels[i]) begin
                func_active = 1'b1;
            end
        end
    end
endfunction

reg [`MS_TICK_W-1:0] tick_count;
reg ms_tick;
wire [`NUM_TERMINALS-1:0] level;
wire [`FILTER_MS_W-1:0] low_ms;
wire [`FILTER_MS_W-1:0] high_ms;

assign low_ms = clamp_ms(input_filter_time_low_group);
assign high_ms = clamp_ms(input_filter_time_high_group);

always @(posedge clk) begin
    if (!resetn) begin
        tick_count <= {`MS_TICK_W{1'b0}};
        ms_tick <= 1'b0;
    end else begin
        ms_tick <= (tick_count == TICK_LAST);
        if (tick_count == TICK_LAST) begin
            tick_count <= {`MS_TICK_W{1'b0}};
        end else begin
            tick_count <= tick_count + TICK_ONE;
        end
    end
end

genvar g;
generate
    for (g = 0; g < `NUM_TERMINALS; g = g + 1) begin : terminal
        input_debounce filter (
            .clk(clk),
            .resetn(resetn),
            .ms_tick(ms_tick),
            .filter_ms((g < 5) ? low_ms : high_ms),
            .pin(terminal_pin[g]),
            .level(level[g])
        );
    end
endgenerate

// decoded function levels, filtered only
wire f_updn_clear = func_active(level, terminal_func, `FN_UPDN_CLEAR);
wire f_ext_fault = func_active(level, terminal_func, `FN_EXT_FAULT);
wire f_three_line = func_active(level, terminal_func, `FN_THREE_LINE);
wire f_brake = func_active(level, terminal_func, `FN_DC_BRAKE_HOLD);
wire f_ramp_hold = func_active(level, terminal_func, `FN_RAMP_HOLD);
wire f_proc_loop = func_active(level, terminal_func, `FN_PROC_LOOP_EN);
wire f_staged = func_active(level, terminal_func, `FN_STAGED_EN);
wire f_swing = func_active(level, terminal_func, `FN_SWING_EN);
wire f_comp = func_active(level, terminal_func, `FN_COMP_LOOP_EN);
wire f_staged_reset = func_active(level, terminal_func, `FN_STAGED_RESET);
wire f_swing_reset = func_active(level, terminal_func, `FN_SWING_RESET);
wire f_sp0 = func_active(level, terminal_func, `FN_SETPOINT_B0);
wire f_sp1 = func_active(level, terminal_func, `FN_SETPOINT_B1);
wire f_sp2 = func_active(level, terminal_func, `FN_SETPOINT_B2);
wire f_sp_src = func_active(level, terminal_func, `FN_SETPOINT_SRC);
wire f_fb_src = func_active(level, terminal_func, `FN_FEEDBACK_SRC);
wire f_sleep = func_active(level, terminal_func, `FN_LOOP_SLEEP);
wire f_speed = func_active(level, terminal_func, `FN_SPEED_MODE);
wire f_min_tq = func_active(level, terminal_func, `FN_MIN_TORQUE_SEL);
wire f_max_tq = func_active(level, terminal_func, `FN_MAX_TORQUE_SEL);

wire three_line_mode = (run_command_source == `RUN_SRC_TERMINAL) &&
    (terminal_wiring_mode == `WIRING_THREE_A || terminal_wiring_mode == `WIRING_THREE_B);
wire brake_window = decel_stopping && below_brake_threshold;
wire stop_memory = (staged_program_mode_memory == `STOP_MEMORY_1) ||
    (staged_program_mode_memory == `STOP_MEMORY_2);
wire swing_terminal = (swing_run_config_enable == `TERMINAL_SELECT);

always @(posedge clk) begin
    if (!resetn) begin
        updn_setpoint_clear <= 1'b0;
        ext_fault_stop <= 1'b0;
        fault_code <= 8'h00;
        three_line_enable <= 1'b0;
        three_line_stop_n <= 1'b0;
        dc_brake_hold <= 1'b0;
        dc_brake_timer_ignore <= 1'b0;
        ramp_hold <= 1'b0;
        proc_loop_enable <= 1'b0;
        staged_program_enable <= 1'b0;
        swing_enable <= 1'b0;
        swing_to_preset <= 1'b0;
        comp_loop_enable <= 1'b0;
        staged_position_clear <= 1'b0;
        swing_state_clear <= 1'b0;
        setpoint_stage <= 3'h0;
        setpoint_source_2 <= 1'b0;
        feedback_source_2 <= 1'b0;
        loop_sleep <= 1'b0;
        speed_mode <= 1'b0;
        min_torque_limit_2 <= 1'b0;
        max_torque_limit_2 <= 1'b0;
    end else begin
        // only the up/down accumulator sees this clear
        updn_setpoint_clear <= f_updn_clear;
        // fault stays latched; a new fault wins over a same-cycle clear
        if (f_ext_fault) begin
            ext_fault_stop <= 1'b1;
            fault_code <= `FAULT_EXT_EQUIPMENT;
        end else if (fault_clear) begin
            ext_fault_stop <= 1'b0;
            fault_code <= 8'h00;
        end
        three_line_enable <= three_line_mode;
        three_line_stop_n <= three_line_mode && f_three_line;
        // brake follows the input, never a timer, inside the stop window
        dc_brake_hold <= brake_window && f_brake;
        dc_brake_timer_ignore <= brake_window && f_brake;
        ramp_hold <= f_ramp_hold;
        proc_loop_enable <= proc_loop_terminal_select && f_proc_loop;
        staged_program_enable <= (staged_program_mode_run == `TERMINAL_SELECT) && f_staged;
        swing_enable <= swing_terminal && f_swing;
        // ramp time choice is left to the ramp block, default time 1
        swing_to_preset <= swing_terminal && !f_swing;
        comp_loop_enable <= (compensation_loop_enable_source == `TERMINAL_SELECT) && f_comp;
        staged_position_clear <= stop_memory && f_staged_reset;
        swing_state_clear <= (swing_run_config_memory == `SWING_MEMORY_AT_STOP) && f_swing_reset;
        setpoint_stage <= {f_sp2, f_sp1, f_sp0};
        setpoint_source_2 <= f_sp_src;
        feedback_source_2 <= f_fb_src;
        loop_sleep <= (loop_sleep_source == `TERMINAL_SELECT) && f_sleep;
        speed_mode <= f_speed;
        min_torque_limit_2 <= f_min_tq;
        max_torque_limit_2 <= f_max_tq;
    end
end

endmodule

// ==== mfi_decoder_chk.sv ====
// checker for the input decoder: gating, latch and exclusion relations
// assumes a bind into mfi_decoder, one clock domain
`timescale 1ns/1ps
`include "mfi_decoder_map.vh"
module mfi_decoder_chk (
    // clock and reset
    input wire clk,
    input wire resetn,
    // configuration and drive state
    input wire [3:0] staged_program_mode_run,
    input wire [3:0] compensation_loop_enable_source,
    input wire [3:0] loop_sleep_source,
    input wire decel_stopping,
    input wire below_brake_threshold,
    input wire fault_clear,
    // actions
    input wire ext_fault_stop,
    input wire [7:0] fault_code,
    input wire three_line_enable,
    input wire three_line_stop_n,
    input wire dc_brake_hold,
    input wire staged_program_enable,
    input wire comp_loop_enable,
    input wire loop_sleep,
    input wire swing_enable,
    input wire swing_to_preset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence staged_off;
        staged_program_mode_run != `TERMINAL_SELECT;
    endsequence
    sequence fault_held;
        ext_fault_stop && !fault_clear;
    endsequence
    fault_code_a: assert property (fault_code == (ext_fault_stop ? `FAULT_EXT_EQUIPMENT : 8'h00))
        else $error("fault code does not follow latch");
    fault_hold_a: assert property (fault_held |=> ext_fault_stop)
        else $error("fault latch dropped without clear");
    three_line_a: assert property (three_line_stop_n |-> three_line_enable)
        else $error("third wire active outside three-line mode");
    brake_gate_a: assert property (dc_brake_hold |-> $past(decel_stopping && below_brake_threshold))
        else $error("brake hold outside low-speed stop");
    staged_gate_a: assert property (staged_off |=> !staged_program_enable)
        else $error("staged program on without terminal mode");
    swing_excl_a: assert property (!(swing_enable && swing_to_preset))
        else $error("swing and preset ramp together");
    comp_gate_a: assert property (comp_loop_enable |-> $past(compensation_loop_enable_source) == `TERMINAL_SELECT)
        else $error("compensation loop on without terminal mode");
    sleep_gate_a: assert property (loop_sleep |-> $past(loop_sleep_source) == `TERMINAL_SELECT)
        else $error("loop sleep without terminal mode");
endmodule
bind mfi_decoder mfi_decoder_chk chk (.clk(clk), .resetn(resetn),
    .staged_program_mode_run(staged_program_mode_run),
    .compensation_loop_enable_source(compensation_loop_enable_source),
    .loop_sleep_source(loop_sleep_source), .decel_stopping(decel_stopping),
    .below_brake_threshold(below_brake_threshold), .fault_clear(fault_clear),
    .ext_fault_stop(ext_fault_stop), .fault_code(fault_code), .three_line_enable(three_line_enable),
    .three_line_stop_n(three_line_stop_n), .dc_brake_hold(dc_brake_hold),
    .staged_program_enable(staged_program_enable), .comp_loop_enable(comp_loop_enable),
    .loop_sleep(loop_sleep), .swing_enable(swing_enable), .swing_to_preset(swing_to_preset));

// ==== mfi_decoder_map.vh ====
// constants for the multifunction input decoder: function codes, mode values, filter timing
// assumes a 100 MHz clock and per-terminal 7-bit function codes
`ifndef MFI_DECODER_MAP_VH
`define MFI_DECODER_MAP_VH

`define NUM_TERMINALS 9
`define FUNC_CODE_W 7
`define FILTER_MS_W 6

// function codes
`define FN_UPDN_CLEAR 7'h11
`define FN_EXT_FAULT 7'h12
`define FN_THREE_LINE 7'h13
`define FN_DC_BRAKE_HOLD 7'h14
`define FN_RAMP_HOLD 7'h15
`define FN_PROC_LOOP_EN 7'h16
`define FN_STAGED_EN 7'h17
`define FN_SWING_EN 7'h18
`define FN_COMP_LOOP_EN 7'h19
`define FN_STAGED_RESET 7'h1A
`define FN_SWING_RESET 7'h1B
`define FN_SETPOINT_B0 7'h1C
`define FN_SETPOINT_B1 7'h1D
`define FN_SETPOINT_B2 7'h1E
`define FN_SETPOINT_SRC 7'h1F
`define FN_FEEDBACK_SRC 7'h20
`define FN_LOOP_SLEEP 7'h21
`define FN_SPEED_MODE 7'h22
`define FN_MIN_TORQUE_SEL 7'h23
`define FN_MAX_TORQUE_SEL 7'h24

// configuration values
`define RUN_SRC_TERMINAL 4'h1
`define WIRING_THREE_A 4'h2
`define WIRING_THREE_B 4'h3
`define TERMINAL_SELECT 4'h2
`define STOP_MEMORY_1 4'h1
`define STOP_MEMORY_2 4'h2
`define SWING_MEMORY_AT_STOP 4'h0
`define FAULT_EXT_EQUIPMENT 8'h11

// filter timing
`define FILTER_DEFAULT_MS 6'h05
`define FILTER_MIN_MS 6'h01
`define FILTER_MAX_MS 6'h32
`define CLK_FREQ_HZ 100000000
`define MS_PER_S 1000
`define CYCLES_PER_MS (`CLK_FREQ_HZ / `MS_PER_S)
`define MS_TICK_W 17
`define MS_TICK_LAST 17'h1869F

`endif

// ==== tb_top.sv ====
// self-checking bench for the input decoder, one terminal carries every function in turn
// assumes contact_bank drives the pins and the filter times sit at 1 ms
`timescale 1ns/1ps
`include "mfi_decoder_map.vh"
module tb_top;
    reg clk = 1'b0, resetn = 1'b0, fault_clear = 1'b0;
    reg decel_stopping = 1'b1, below_brake_threshold = 1'b1, proc_loop_terminal_select = 1'b1;
    reg [8:0] close = 9'h000;
    wire [8:0] terminal_pin;
    reg [62:0] terminal_func = 63'h0;
    reg [3:0] run_command_source = 4'h1, terminal_wiring_mode = 4'h2, staged_program_mode_run = 4'h2;
    reg [3:0] staged_program_mode_memory = 4'h1, swing_run_config_enable = 4'h2;
    reg [3:0] swing_run_config_memory = 4'h0, compensation_loop_enable_source = 4'h2, loop_sleep_source = 4'h2;
    wire updn_setpoint_clear, ext_fault_stop, three_line_enable, three_line_stop_n, dc_brake_hold;
    wire dc_brake_timer_ignore, ramp_hold, proc_loop_enable, staged_program_enable, swing_enable;
    wire swing_to_preset, comp_loop_enable, staged_position_clear, swing_state_clear, setpoint_source_2;
    wire feedback_source_2, loop_sleep, speed_mode, min_torque_limit_2, max_torque_limit_2;
    wire [7:0] fault_code;
    wire [2:0] setpoint_stage;
    // one bit per function code, code 17 at the top
    wire [19:0] acts = {updn_setpoint_clear, ext_fault_stop, three_line_stop_n, dc_brake_hold, ramp_hold,
        proc_loop_enable, staged_program_enable, swing_enable, comp_loop_enable, staged_position_clear,
        swing_state_clear, setpoint_stage[0], setpoint_stage[1], setpoint_stage[2], setpoint_source_2,
        feedback_source_2, loop_sleep, speed_mode, min_torque_limit_2, max_torque_limit_2};
    integer num_errors = 0, checks_done = 0, cycles = 0, i, n;
    contact_bank sw (.clk(clk), .close(close), .pins(terminal_pin));
    mfi_decoder dut (.clk(clk), .resetn(resetn), .terminal_pin(terminal_pin), .terminal_func(terminal_func),
        .input_filter_time_low_group(6'h01), .input_filter_time_high_group(6'h01),
        .run_command_source(run_command_source), .terminal_wiring_mode(terminal_wiring_mode),
        .staged_program_mode_run(staged_program_mode_run), .staged_program_mode_memory(staged_program_mode_memory),
        .swing_run_config_enable(swing_run_config_enable), .swing_run_config_memory(swing_run_config_memory),
        .compensation_loop_enable_source(compensation_loop_enable_source), .loop_sleep_source(loop_sleep_source),
        .proc_loop_terminal_select(proc_loop_terminal_select), .decel_stopping(decel_stopping),
        .below_brake_threshold(below_brake_threshold), .fault_clear(fault_clear),
        .updn_setpoint_clear(updn_setpoint_clear), .ext_fault_stop(ext_fault_stop), .fault_code(fault_code),
        .three_line_enable(three_line_enable), .three_line_stop_n(three_line_stop_n),
        .dc_brake_hold(dc_brake_hold), .dc_brake_timer_ignore(dc_brake_timer_ignore), .ramp_hold(ramp_hold),
        .proc_loop_enable(proc_loop_enable), .staged_program_enable(staged_program_enable),
        .swing_enable(swing_enable), .swing_to_preset(swing_to_preset), .comp_loop_enable(comp_loop_enable),
        .staged_position_clear(staged_position_clear), .swing_state_clear(swing_state_clear),
        .setpoint_stage(setpoint_stage), .setpoint_source_2(setpoint_source_2),
        .feedback_source_2(feedback_source_2), .loop_sleep(loop_sleep), .speed_mode(speed_mode),
        .min_torque_limit_2(min_torque_limit_2), .max_torque_limit_2(max_torque_limit_2));
    always #5 clk = ~clk;
    task chk(input [19:0] seen, input [19:0] want);
        checks_done = checks_done + 1;
        if (seen !== want) begin
            num_errors = num_errors + 1;
            $display("BAD at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one filter period plus margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 120000) begin
            num_errors = num_errors + 1;
            stop_test;
        end
    end
    initial begin
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        chk(acts, 20'h0);
        terminal_func[20:14] = `FN_RAMP_HOLD;
        close = 9'h004;
        n = 0;
        while (ramp_hold !== 1'b1 && n < 100100) begin
            @(negedge clk);
            n = n + 1;
        end
        chk(n > 3 && n <= 100005, 1'b1);
        close = 9'h000;
        repeat (20) @(negedge clk);
        close = 9'h004;
        repeat (50) @(negedge clk);
        chk(ramp_hold, 1'b1);
        fault_clear = 1'b1;
        for (i = 0; i < 20; i = i + 1) begin
            terminal_func[20:14] = 7'h11 + i;
            repeat (2) @(negedge clk);
            chk(acts, 20'h80000 >> i);
            chk(fault_code, i == 1 ? 8'h11 : 8'h00);
            chk(swing_to_preset, i != 7);
            chk(dc_brake_timer_ignore, i == 3);
            chk(three_line_enable, 1'b1);
        end
        fault_clear = 1'b0;
        terminal_func[20:14] = `FN_EXT_FAULT;
        repeat (2) @(negedge clk);
        terminal_func[20:14] = 7'h00;
        repeat (3) @(negedge clk);
        chk(ext_fault_stop, 1'b1);
        fault_clear = 1'b1;
        repeat (2) @(negedge clk);
        chk(ext_fault_stop, 1'b0);
        {run_command_source, staged_program_mode_run, swing_run_config_enable} = 12'h000;
        {compensation_loop_enable_source, loop_sleep_source, staged_program_mode_memory} = 12'h000;
        swing_run_config_memory = 4'h1;
        proc_loop_terminal_select = 1'b0;
        below_brake_threshold = 1'b0;
        for (i = 0; i < 9; i = i + 1) begin
            terminal_func[20:14] = 7'h13 + i;
            repeat (2) @(negedge clk);
            chk(acts, i == 2 ? 20'h08000 : 20'h0);
            chk({three_line_enable, swing_to_preset, dc_brake_timer_ignore}, 3'b000);
        end
        stop_test;
    end
endmodule
